// [rtl/cfi_pkg.sv]
// Constants, register map and signal bundles for the card feed interlock and runout block
package cfi_pkg;

    localparam logic [7:0] CFI_OFF_CTRL = 8'h00;
    localparam logic [7:0] CFI_OFF_STATUS = 8'h04;

    localparam int CFI_CTRL_INTERLOCK_EN = 0;
    localparam int CFI_CTRL_SW_RUNOUT = 1;
    localparam logic CFI_RST_INTERLOCK_EN = 1'b1;

    localparam int CFI_ST_RUNOUT = 0;
    localparam int CFI_ST_FEED_FAIL = 1;
    localparam int CFI_ST_STOP_LIGHT = 2;
    localparam int CFI_ST_BLOCK = 3;
    localparam int CFI_ST_FEED_RUN = 4;
    localparam int CFI_ST_START_HOLD = 5;
    localparam int CFI_ST_HOPPER = 6;
    localparam int CFI_ST_RUNIN_LSB = 8;

    localparam logic [2:0] CFI_RUNIN_LAST = 3'h3;
    localparam logic [2:0] CFI_RUNIN_FOURTH = 3'h4;

    localparam logic [1:0] CFI_HTRANS_NONSEQ = 2'h2;

    // Operator keys and card feed sensors, all asynchronous to hclk
    typedef struct packed {
        logic start_key;
        logic runout_key;
        logic fi_start_key;
        logic hopper_full;
        logic lever_one;
        logic lever_two;
        logic lever_three;
        logic compare_diff;
        logic cycle_pulse;
    } cfi_pins_s;

    typedef struct packed {
        logic high_speed_clutch;
        logic feed_clutch;
        logic exit_suppress;
        logic exit_suppress_aux;
        logic non_print;
        logic list_control;
        logic print_clutch;
        logic form_space;
        logic accumulate;
        logic stop_light;
        logic program_start;
        logic start_hold;
    } cfi_outs_s;

endpackage : cfi_pkg

// [rtl/cfi_interlock.sv]
// Card feed interlock and non-print runout sequencer with AHB-Lite register slave
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module cfi_interlock
    import cfi_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire cfi_pins_s pins,
    output cfi_outs_s outs
);

    cfi_pins_s sync1_r;
    cfi_pins_s sync2_r;
    logic cyc_prev_r;
    logic cyc;

    logic hopper_a_r, hopper_b_r;
    logic lever_one_relay_a_r, lever_one_relay_b_r;
    logic lever_two_relay_r, lever_three_relay_r;
    logic runout_latch_r;
    logic high_speed_clutch_relay_r, runout_feed_relay_r;
    logic exit_suppress_relay_r, exit_suppress_aux_relay_r, non_print_relay_r;
    logic start_hold_relay_r;
    logic feed_failure_latch_r, stop_light_relay_r;
    logic program_block_latch_r, block_companion_relay_r;
    logic feed_run_relay_r;
    logic [2:0] runin_cnt_r;
    logic runin_fourth;
    logic runout_key_ok, fail, feed_empty, release_il;
    logic prog_start_nxt;

    logic interlock_en_r, sw_runout_r;
    logic ap_valid_r, ap_write_r;
    logic [7:0] ap_addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] status;
    cfi_outs_s outs_nxt, outs_r;

    // Only the second flop of the synchroniser feeds logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            cyc_prev_r <= 1'b0;
        end else if (ce) begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            cyc_prev_r <= sync2_r.cycle_pulse;
        end
    end

    // One enable per card-feed cycle paces the lever, runout, clutch, start-hold, block and feed-run relays
    assign cyc = ce && sync2_r.cycle_pulse && !cyc_prev_r;

    assign runout_key_ok = (sync2_r.runout_key || sw_runout_r) && !hopper_b_r
                           && !stop_light_relay_r && !start_hold_relay_r;
    assign feed_empty = !lever_one_relay_a_r && !lever_two_relay_r && !lever_three_relay_r;
    assign fail = cyc && interlock_en_r && start_hold_relay_r && hopper_b_r
                  && !sync2_r.lever_one && !feed_failure_latch_r;
    assign runin_fourth = program_block_latch_r && (runin_cnt_r == CFI_RUNIN_FOURTH);
    assign release_il = cyc && runin_fourth;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hopper_a_r <= 1'b0;
            hopper_b_r <= 1'b0;
        end else if (ce) begin
            // Hopper relays follow the cards directly, not the cam cycle, so a key
            // sampled on the same cycle edge already sees a loaded hopper
            hopper_a_r <= sync2_r.hopper_full;
            hopper_b_r <= sync2_r.hopper_full;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lever_one_relay_a_r <= 1'b0;
            lever_one_relay_b_r <= 1'b0;
            lever_two_relay_r <= 1'b0;
            lever_three_relay_r <= 1'b0;
        end else if (cyc) begin
            lever_one_relay_a_r <= sync2_r.lever_one;
            lever_one_relay_b_r <= sync2_r.lever_one;
            lever_two_relay_r <= sync2_r.lever_two;
            // Once dropped under interlock, stays down until run-in restores feed run
            lever_three_relay_r <= sync2_r.lever_three
                && !(feed_failure_latch_r && !lever_three_relay_r && !feed_run_relay_r);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            runout_latch_r <= 1'b0;
        end else if (cyc) begin
            if (runout_latch_r && feed_empty) begin
                runout_latch_r <= 1'b0;
            end else if (runout_key_ok) begin
                runout_latch_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_speed_clutch_relay_r <= 1'b0;
            runout_feed_relay_r <= 1'b0;
            exit_suppress_relay_r <= 1'b0;
        end else if (cyc) begin
            high_speed_clutch_relay_r <= runout_latch_r;
            runout_feed_relay_r <= runout_latch_r;
            exit_suppress_relay_r <= runout_latch_r
                || (program_block_latch_r && runin_cnt_r == CFI_RUNIN_LAST);
        end
    end

    // Aux suppression and non-print follow the suppression relay one clock later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exit_suppress_aux_relay_r <= 1'b0;
            non_print_relay_r <= 1'b0;
        end else if (ce) begin
            exit_suppress_aux_relay_r <= exit_suppress_relay_r;
            non_print_relay_r <= exit_suppress_relay_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_hold_relay_r <= 1'b0;
        end else if (cyc) begin
            if (feed_failure_latch_r && !release_il) begin
                // Interlock key feeds one cycle at a time while it is held
                start_hold_relay_r <= sync2_r.fi_start_key
                    && (program_block_latch_r ? hopper_b_r : !hopper_b_r);
            end else if (fail) begin
                start_hold_relay_r <= 1'b0;
            end else if (sync2_r.start_key || runout_key_ok) begin
                start_hold_relay_r <= 1'b1;
            end else if (!hopper_b_r && feed_empty && !runout_latch_r) begin
                start_hold_relay_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            feed_failure_latch_r <= 1'b0;
        end else if (fail) begin
            feed_failure_latch_r <= 1'b1;
        end else if (release_il) begin
            feed_failure_latch_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stop_light_relay_r <= 1'b0;
            block_companion_relay_r <= 1'b0;
        end else if (ce) begin
            stop_light_relay_r <= feed_failure_latch_r;
            block_companion_relay_r <= program_block_latch_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            program_block_latch_r <= 1'b0;
        end else if (cyc) begin
            if (release_il) begin
                program_block_latch_r <= 1'b0;
            end else if (feed_failure_latch_r && start_hold_relay_r && !lever_two_relay_r) begin
                program_block_latch_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            feed_run_relay_r <= 1'b1;
        end else if (cyc) begin
            if (program_block_latch_r && runin_cnt_r == CFI_RUNIN_LAST) begin
                feed_run_relay_r <= 1'b1;
            end else if (feed_failure_latch_r && !sync2_r.lever_three) begin
                // Drops on the cycle the last card clears the third station
                feed_run_relay_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            runin_cnt_r <= '0;
        end else if (cyc) begin
            if (release_il) begin
                runin_cnt_r <= '0;
            end else if (program_block_latch_r && start_hold_relay_r && !runin_fourth) begin
                runin_cnt_r <= runin_cnt_r + 3'h1;
            end
        end
    end

    // Program start is the only place a control break leaves the block
    // The block latch picks on the very cycle whose break it must stop, so the
    // picking condition itself also masks program start
    assign prog_start_nxt = cyc && start_hold_relay_r && sync2_r.compare_diff
                            && !program_block_latch_r
                            && !(feed_failure_latch_r && !lever_two_relay_r);

    always_comb begin
        outs_nxt = '0;
        outs_nxt.high_speed_clutch = high_speed_clutch_relay_r;
        outs_nxt.feed_clutch = runout_feed_relay_r || start_hold_relay_r;
        outs_nxt.exit_suppress = exit_suppress_relay_r;
        outs_nxt.exit_suppress_aux = exit_suppress_aux_relay_r;
        outs_nxt.non_print = non_print_relay_r;
        outs_nxt.list_control = start_hold_relay_r && !non_print_relay_r
                                && !runin_fourth;
        outs_nxt.print_clutch = outs_nxt.list_control;
        // Spacing rides on the print cams, so it dies with the print clutch
        outs_nxt.form_space = outs_nxt.print_clutch;
        outs_nxt.accumulate = start_hold_relay_r && !exit_suppress_relay_r
                              && !runin_fourth;
        outs_nxt.stop_light = stop_light_relay_r;
        outs_nxt.program_start = prog_start_nxt;
        outs_nxt.start_hold = start_hold_relay_r;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            outs_r <= '0;
        end else if (ce) begin
            outs_r <= outs_nxt;
        end
    end

    assign outs = outs_r;

    // AHB-Lite slave: zero wait states while ce is high, stalls while ce is low
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    always_comb begin
        status = '0;
        status[CFI_ST_RUNOUT] = runout_latch_r;
        status[CFI_ST_FEED_FAIL] = feed_failure_latch_r;
        status[CFI_ST_STOP_LIGHT] = stop_light_relay_r;
        status[CFI_ST_BLOCK] = program_block_latch_r;
        status[CFI_ST_FEED_RUN] = feed_run_relay_r;
        status[CFI_ST_START_HOLD] = start_hold_relay_r;
        status[CFI_ST_HOPPER] = hopper_b_r;
        status[CFI_ST_RUNIN_LSB +: 3] = runin_cnt_r;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_r <= 1'b0;
            ap_write_r <= 1'b0;
            ap_addr_r <= '0;
            hrdata_r <= '0;
        end else if (ce && hready) begin
            ap_valid_r <= hsel && htrans == CFI_HTRANS_NONSEQ && hsize == 3'h2;
            ap_write_r <= hwrite;
            ap_addr_r <= haddr[7:0];
            hrdata_r <= '0;
            if (hsel && htrans[1] && !hwrite) begin
                case (haddr[7:0])
                    CFI_OFF_CTRL: hrdata_r <= {30'h0000_0000, sw_runout_r, interlock_en_r};
                    CFI_OFF_STATUS: hrdata_r <= status;
                    default: hrdata_r <= '0;
                endcase
            end
        end
    end

    // A software runout request waits for the next cycle; the request wins over consumption
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interlock_en_r <= CFI_RST_INTERLOCK_EN;
            sw_runout_r <= 1'b0;
        end else if (ce) begin
            if (ap_valid_r && ap_write_r && ap_addr_r == CFI_OFF_CTRL) begin
                interlock_en_r <= hwdata[CFI_CTRL_INTERLOCK_EN];
                sw_runout_r <= hwdata[CFI_CTRL_SW_RUNOUT] || (sw_runout_r && !cyc);
            end else if (cyc) begin
                sw_runout_r <= 1'b0;
            end
        end
    end

    sequence s_fail;
        fail;
    endsequence

    sequence s_latch_then_light;
        feed_failure_latch_r ##1 stop_light_relay_r;
    endsequence

    property p_runout_empty;
        @(posedge hclk) disable iff (!hresetn)
        $rose(runout_latch_r) |-> !$past(hopper_b_r);
    endproperty
    a_runout_empty: assert property (p_runout_empty) else $error("runout began with cards in hopper");

    property p_hs_clutch;
        @(posedge hclk) disable iff (!hresetn)
        (cyc && runout_latch_r) |=> high_speed_clutch_relay_r ##1 outs.high_speed_clutch;
    endproperty
    a_hs_clutch: assert property (p_hs_clutch) else $error("high-speed clutch not held");

    property p_exit_sup;
        @(posedge hclk) disable iff (!hresetn)
        (cyc && runout_latch_r) |=> exit_suppress_relay_r ##1 exit_suppress_aux_relay_r;
    endproperty
    a_exit_sup: assert property (p_exit_sup) else $error("exits not suppressed");

    property p_non_print;
        @(posedge hclk) disable iff (!hresetn)
        outs.non_print |-> !outs.print_clutch && !outs.list_control && !outs.form_space;
    endproperty
    a_non_print: assert property (p_non_print) else $error("print or list active in non-print");

    property p_fail_latch;
        @(posedge hclk) disable iff (!hresetn)
        s_fail |=> s_latch_then_light ##1 outs.stop_light;
    endproperty
    a_fail_latch: assert property (p_fail_latch) else $error("feed failure not latched");

    property p_keys_locked;
        @(posedge hclk) disable iff (!hresetn)
        (feed_failure_latch_r && hopper_b_r && !program_block_latch_r) |=>
            !$rose(start_hold_relay_r) && !$rose(runout_latch_r);
    endproperty
    a_keys_locked: assert property (p_keys_locked) else $error("key acted with hopper full");

    property p_block_prog;
        @(posedge hclk) disable iff (!hresetn)
        outs.program_start |-> !$past(program_block_latch_r, 1) && !program_block_latch_r;
    endproperty
    a_block_prog: assert property (p_block_prog) else $error("program start while blocked");

    property p_release;
        @(posedge hclk) disable iff (!hresetn)
        release_il |=> !feed_failure_latch_r && !program_block_latch_r ##2 !outs.stop_light;
    endproperty
    a_release: assert property (p_release) else $error("interlock did not release");

endmodule : cfi_interlock

// [bench/cfi_feed_model.sv]
// Operator keys and card feed sensors facing the interlock block
`timescale 1ns/1ps
module cfi_feed_model
    import cfi_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cyc_req,
    input wire logic [2:0] key_req,
    input wire logic hopper,
    input wire logic [2:0] lever,
    input wire logic diff,
    output logic busy,
    output cfi_pins_s pins
);
    logic [3:0] phase_r;
    logic [2:0] keys_r;

    // Keys stay down for the whole cam cycle so the sampled pulse edge always sees them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy <= 1'b0;
            phase_r <= 4'h0;
            keys_r <= 3'h0;
        end else if (busy) begin
            phase_r <= phase_r + 4'h1;
            if (phase_r == 4'hf) begin
                busy <= 1'b0;
                keys_r <= 3'h0;
            end
        end else if (cyc_req) begin
            busy <= 1'b1;
            keys_r <= key_req;
        end
    end

    // The cam breaker only turns while a cycle is under way
    always_comb begin
        pins.start_key = keys_r[2];
        pins.runout_key = keys_r[1];
        pins.fi_start_key = keys_r[0];
        pins.hopper_full = hopper;
        pins.lever_one = lever[0];
        pins.lever_two = lever[1];
        pins.lever_three = lever[2];
        pins.compare_diff = diff;
        pins.cycle_pulse = busy && (phase_r >= 4'h2) && (phase_r < 4'h8);
    end
endmodule : cfi_feed_model

// [bench/test_card_feed_interlock_runout.sv]
// Self-checking bench for the card feed interlock and non-print runout block
`timescale 1ns/1ps
module test_card_feed_interlock_runout
    import cfi_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic cyc_req = 1'b0;
    logic [2:0] key_req = 3'h0;
    logic hopper = 1'b0;
    logic [2:0] lever = 3'h0;
    logic diff = 1'b0;
    logic busy;
    cfi_pins_s pins;
    cfi_outs_s outs;
    logic [31:0] rdat;
    int mismatches = 0;
    int comparisons = 0;
    int pulses = 0;
    int p0;

    always #10 hclk = ~hclk;

    cfi_interlock dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .outs(outs));

    cfi_feed_model model (.hclk(hclk), .hresetn(hresetn), .cyc_req(cyc_req),
        .key_req(key_req), .hopper(hopper), .lever(lever), .diff(diff), .busy(busy),
        .pins(pins));

    always @(posedge hclk) begin
        if (outs.program_start === 1'b1) pulses++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // Slave may stall through ce, so the wait is bounded rather than fixed
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 100) begin
            n++;
            @(posedge hclk);
        end
        if (n >= 100) check(32'h0, 32'h1);
    endtask : wait_ready

    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= CFI_HTRANS_NONSEQ;
        haddr <= addr;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdat = hrdata;
    endtask : ahb

    // One card-feed cycle: keys {start, runout, interlock start}, levers {three, two, one}
    task automatic cycle(input logic [2:0] k, input logic h, input logic [2:0] lv, input logic d);
        key_req <= k;
        hopper <= h;
        lever <= lv;
        diff <= d;
        cyc_req <= 1'b1;
        @(posedge hclk);
        cyc_req <= 1'b0;
        repeat (2) @(posedge hclk);
        for (int i = 0; i < 40 && busy === 1'b1; i++) @(posedge hclk);
        repeat (6) @(posedge hclk);
    endtask : cycle

    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        give_verdict();
    end

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check(outs, 32'h0);
        check(hresp, 32'h0);
        ahb(1'b0, CFI_OFF_CTRL, 32'h0);
        check(rdat, 32'h1);
        ahb(1'b0, CFI_OFF_STATUS, 32'h0);
        check(rdat, 32'h0000_0010);
        ahb(1'b1, 32'h0000_0008, 32'hffff_ffff);
        ahb(1'b0, 32'h0000_0008, 32'h0);
        check(rdat, 32'h0);
        ahb(1'b1, CFI_OFF_CTRL, 32'h0);
        ahb(1'b0, CFI_OFF_CTRL, 32'h0);
        check(rdat, 32'h0);
        ahb(1'b1, CFI_OFF_CTRL, 32'h1);
        ce <= 1'b0;
        @(posedge hclk);
        check(hreadyout, 32'h0);
        ce <= 1'b1;
        $display("test reset and registers done");

        cycle(3'b010, 1'b1, 3'b111, 1'b0);
        ahb(1'b0, CFI_OFF_STATUS, 32'h0);
        check(rdat[0], 32'h0);
        check(outs.high_speed_clutch, 32'h0);
        cycle(3'b010, 1'b0, 3'b111, 1'b0);
        ahb(1'b0, CFI_OFF_STATUS, 32'h0);
        check(rdat[0], 32'h1);
        cycle(3'b000, 1'b0, 3'b111, 1'b0);
        check(outs.high_speed_clutch, 32'h1);
        check(outs.feed_clutch, 32'h1);
        check({outs.exit_suppress, outs.exit_suppress_aux}, 32'h3);
        check({outs.non_print, outs.print_clutch, outs.list_control}, 32'h4);
        check(outs.form_space, 32'h0);
        cycle(3'b000, 1'b0, 3'b110, 1'b0);
        cycle(3'b000, 1'b0, 3'b100, 1'b0);
        ahb(1'b0, CFI_OFF_STATUS, 32'h0);
        check(rdat[0], 32'h1);
        repeat (3) cycle(3'b000, 1'b0, 3'b000, 1'b0);
        ahb(1'b0, CFI_OFF_STATUS, 32'h0);
        check(rdat[0], 32'h0);
        check(outs.high_speed_clutch, 32'h0);
        $display("test non-print runout done");

        cycle(3'b100, 1'b1, 3'b111, 1'b0);
        check(outs.start_hold, 32'h1);
        cycle(3'b000, 1'b1, 3'b110, 1'b0);
        check(outs.start_hold, 32'h0);
        check(outs.stop_light, 32'h1);
        ahb(1'b0, CFI_OFF_STATUS, 32'h0);
        check(rdat[2:1], 32'h3);
        cycle(3'b111, 1'b1, 3'b110, 1'b1);
        check(outs.start_hold, 32'h0);
        ahb(1'b0, CFI_OFF_STATUS, 32'h0);
        check(rdat[0], 32'h0);
        cycle(3'b000, 1'b0, 3'b110, 1'b0);
        cycle(3'b001, 1'b0, 3'b110, 1'b0);
        p0 = pulses;
        cycle(3'b001, 1'b0, 3'b100, 1'b1);
        check(outs.stop_light, 32'h1);
        check(pulses > p0, 32'h1);
        p0 = pulses;
        cycle(3'b001, 1'b0, 3'b000, 1'b1);
        check(pulses, p0);
        ahb(1'b0, CFI_OFF_STATUS, 32'h0);
        check(rdat[4:1], 32'h7);
        $display("test feed failure runout done");

        cycle(3'b001, 1'b1, 3'b001, 1'b0);
        cycle(3'b001, 1'b1, 3'b011, 1'b0);
        cycle(3'b001, 1'b1, 3'b111, 1'b1);
        check(pulses, p0);
        check(outs.stop_light, 32'h1);
        ahb(1'b0, CFI_OFF_STATUS, 32'h0);
        check({rdat[10:8], rdat[6]}, 32'h7);
        cycle(3'b001, 1'b1, 3'b111, 1'b0);
        check({outs.exit_suppress, outs.non_print}, 32'h3);
        check({outs.accumulate, outs.print_clutch}, 32'h0);
        ahb(1'b0, CFI_OFF_STATUS, 32'h0);
        check(rdat[4], 32'h1);
        cycle(3'b001, 1'b1, 3'b111, 1'b0);
        check(outs.stop_light, 32'h0);
        ahb(1'b0, CFI_OFF_STATUS, 32'h0);
        check(rdat[3:1], 32'h0);
        p0 = pulses;
        cycle(3'b100, 1'b1, 3'b111, 1'b1);
        check(pulses > p0, 32'h1);
        $display("test run-in done");
        give_verdict();
    end
endmodule : test_card_feed_interlock_runout
